// File: rtl/sysctl_seq_pkg.sv
/*
 Constants and carrier types for the system control sequence assembler.
 Assumes one 250 MHz clock and frame/symbol strobes from the modulator timing.
*/
// What this block does
// - Merge configuration with sync, parity, reserved bits
// - Emit eight 32-bit sequences once per frame
// - Report block count to Layer 2 each block
// - One bit per vector element, serial stream
// - Sequence bit 31 first at index 32j
// - Fixed sync patterns at 31:25, 22, 17, 10:9
// - Field positions for flags, count, mode code
// - Four even parity bits over their groups
// - Block count modulo 8 per 32 symbols
package sysctl_seq_pkg;
	localparam int SEQ_BITS = 32;
	localparam int BLOCKS_PER_FRAME = 8;
	localparam int CNT_W = 3;
	localparam int MODE_W = 5;
	localparam int BITIDX_W = 5;
	localparam logic [6:0] SYNC_HI_VAL = 7'h32;
	localparam logic SYNC_B22_VAL = 1'b1;
	localparam logic SYNC_B17_VAL = 1'b0;
	localparam logic [1:0] SYNC_LO_VAL = 2'h3;
	localparam logic RSVD_VAL = 1'b0;
	localparam logic [BITIDX_W-1:0] FIRST_BIT = 5'h1F;
	localparam logic [BITIDX_W-1:0] LAST_BIT = 5'h00;
	localparam logic [CNT_W-1:0] LAST_BLOCK = 3'h7;

	typedef struct packed {
		logic power_level_flag;
		logic high_power_pids_flag;
		logic analog_audio_width_flag;
		logic reduced_digital_width_flag;
		logic [MODE_W-1:0] service_mode_code;
	} sys_config_s;

	typedef struct packed {
		logic bit_value;
		logic frame_start;
		logic [CNT_W-1:0] block_counter;
	} ref_elem_s;
endpackage

// File: rtl/sysctl_seq_assembler.sv
/*
 System control sequence assembler: builds each 32-bit block sequence and
 streams it MSB first, one bit per symbol, through a two-entry buffer.
 Assumes symbol_tick is one clock per OFDM symbol and frame_tick coincides
 with the first symbol of a frame; the receiver may stall with out_ready.
*/
`timescale 1ns/1ns
module sysctl_seq_assembler
	import sysctl_seq_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic sync_rst,
	input wire logic symbol_tick,
	input wire logic frame_tick,
	input wire sys_config_s cfg,
	output logic in_ready,
	output logic out_valid,
	input wire logic out_ready,
	output ref_elem_s out_elem,
	output logic block_tick,
	output logic [CNT_W-1:0] block_count_out
);
	// ==========================================
	// Sequence assembly
	logic [CNT_W-1:0] blk_reg, blk_next;
	logic [BITIDX_W-1:0] bit_reg, bit_next;
	logic active_reg, active_next;
	sys_config_s cfg_reg, cfg_next;
	logic [SEQ_BITS-1:0] seq;
	logic eff_pl, eff_hpp;
	logic take;

	// Power level and high-power PIDs flags are not applicable in reduced bandwidth, so they read zero
	assign eff_pl = cfg_reg.power_level_flag & ~cfg_reg.reduced_digital_width_flag;
	assign eff_hpp = cfg_reg.high_power_pids_flag & ~cfg_reg.reduced_digital_width_flag;

	always_comb begin
		seq = '0;
		seq[31:25] = SYNC_HI_VAL;
		seq[24] = eff_pl;
		seq[23] = eff_pl;
		seq[22] = SYNC_B22_VAL;
		seq[21] = RSVD_VAL;
		seq[20] = eff_hpp;
		seq[19] = cfg_reg.analog_audio_width_flag;
		seq[18] = ^seq[21:19];
		seq[17] = SYNC_B17_VAL;
		seq[16] = cfg_reg.reduced_digital_width_flag;
		seq[15] = RSVD_VAL;
		seq[14:12] = blk_reg;
		seq[11] = ^seq[16:12];
		seq[10:9] = SYNC_LO_VAL;
		seq[8:6] = {3{RSVD_VAL}};
		seq[5:1] = cfg_reg.service_mode_code;
		seq[0] = ^seq[8:1];
	end

	// A symbol is only consumed when the buffer can take it; stalls lose no bit
	assign take = symbol_tick & in_ready & (active_reg | frame_tick);

	always_comb begin
		blk_next = blk_reg;
		bit_next = bit_reg;
		active_next = active_reg;
		cfg_next = cfg_reg;
		if (take) begin
			if (frame_tick) begin
				blk_next = '0;
				bit_next = FIRST_BIT - 5'h01;
				active_next = 1'b1;
				cfg_next = cfg;
			end else if (bit_reg == LAST_BIT) begin
				bit_next = FIRST_BIT;
				blk_next = blk_reg + 3'h1;
				cfg_next = cfg; // Config sampled per block boundary
				if (blk_reg == LAST_BLOCK)
					active_next = 1'b0;
			end else begin
				bit_next = bit_reg - 5'h01;
			end
		end
		if (sync_rst) begin
			blk_next = '0;
			bit_next = FIRST_BIT;
			active_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			blk_reg <= '0;
			bit_reg <= FIRST_BIT;
			active_reg <= 1'b0;
			cfg_reg <= '0;
		end else begin
			blk_reg <= blk_next;
			bit_reg <= bit_next;
			active_reg <= active_next;
			cfg_reg <= cfg_next;
		end
	end

	// Element going into the buffer; frame start restarts at bit 31 of block 0
	ref_elem_s in_elem;
	logic [SEQ_BITS-1:0] fseq;
	always_comb begin
		fseq = seq;
		fseq[14:12] = frame_tick ? 3'h0 : blk_reg;
		fseq[11] = ^fseq[16:12];
		in_elem.frame_start = frame_tick;
		in_elem.block_counter = frame_tick ? 3'h0 : blk_reg;
		// First bit of any sequence is sync bit 31, independent of config
		in_elem.bit_value = frame_tick ? fseq[FIRST_BIT] : fseq[bit_reg];
	end

	// ==========================================
	// Block count report
	logic block_tick_reg, block_tick_next;
	logic [CNT_W-1:0] bc_out_reg, bc_out_next;
	always_comb begin
		block_tick_next = take & (frame_tick | bit_reg == FIRST_BIT);
		bc_out_next = block_tick_next ? in_elem.block_counter : bc_out_reg;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			block_tick_reg <= 1'b0;
			bc_out_reg <= '0;
		end else begin
			block_tick_reg <= block_tick_next;
			bc_out_reg <= bc_out_next;
		end
	end
	assign block_tick = block_tick_reg;
	assign block_count_out = bc_out_reg;

	// ==========================================
	// Two-entry output buffer
	ref_elem_s mem [2];
	logic wp_reg, wp_next, rp_reg, rp_next;
	logic [1:0] cnt_reg, cnt_next;
	logic push, pop;
	assign in_ready = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign push = take;
	assign pop = out_valid & out_ready;
	assign out_elem = mem[rp_reg];

	always_comb begin
		wp_next = push ? ~wp_reg : wp_reg;
		rp_next = pop ? ~rp_reg : rp_reg;
		cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
		if (sync_rst) begin
			wp_next = 1'b0;
			rp_next = 1'b0;
			cnt_next = 2'h0;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end
	always_ff @(posedge clk) begin
		if (push)
			mem[wp_reg] <= in_elem;
	end

	// ==========================================
	// Checks
	property p_parity_even;
		@(posedge clk) disable iff (!nrst) active_reg |-> (^seq[24:23] == 1'b0) && (^seq[21:18] == 1'b0)
			&& (^seq[16:11] == 1'b0) && (^seq[8:0] == 1'b0);
	endproperty
	a_parity_even: assert property (p_parity_even) else $error("parity group odd");
	property p_sync;
		@(posedge clk) disable iff (!nrst) seq[31:25] == 7'h32 && seq[22] && !seq[17] && seq[10:9] == 2'h3;
	endproperty
	a_sync: assert property (p_sync) else $error("sync bits wrong");
	property p_rsvd;
		@(posedge clk) disable iff (!nrst) seq[21] == 1'b0 && seq[15] == 1'b0 && seq[8:6] == 3'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_blk_inc;
		@(posedge clk) disable iff (!nrst || sync_rst)
			(take && !frame_tick && bit_reg == 5'h00) |=> blk_reg == $past(blk_reg) + 3'h1;
	endproperty
	a_blk_inc: assert property (p_blk_inc) else $error("block count step wrong");
	property p_bit_dec;
		@(posedge clk) disable iff (!nrst || sync_rst)
			(take && !frame_tick && bit_reg != 5'h00) |=> bit_reg == $past(bit_reg) - 5'h01;
	endproperty
	a_bit_dec: assert property (p_bit_dec) else $error("bit index step wrong");
	property p_frame_first;
		@(posedge clk) disable iff (!nrst || sync_rst)
			(take && frame_tick) |=> blk_reg == 3'h0 && bit_reg == 5'h1E && active_reg;
	endproperty
	a_frame_first: assert property (p_frame_first) else $error("frame start not at bit 31");
	property p_block_report;
		@(posedge clk) disable iff (!nrst)
			(take && bit_reg == 5'h1F && !frame_tick) |=> block_tick && block_count_out == $past(blk_reg);
	endproperty
	a_block_report: assert property (p_block_report) else $error("block count not reported");
	property p_fields;
		@(posedge clk) disable iff (!nrst) seq[5:1] == cfg_reg.service_mode_code && seq[14:12] == blk_reg
			&& seq[16] == cfg_reg.reduced_digital_width_flag;
	endproperty
	a_fields: assert property (p_fields) else $error("field misplaced");
	property p_one_bit;
		@(posedge clk) disable iff (!nrst) (push && !frame_tick) |-> in_elem.bit_value == seq[bit_reg];
	endproperty
	a_one_bit: assert property (p_one_bit) else $error("stream bit mismatch");
	property p_merge;
		@(posedge clk) disable iff (!nrst) cfg_reg.reduced_digital_width_flag |-> !seq[24] && !seq[20];
	endproperty
	a_merge: assert property (p_merge) else $error("flags not cleared in reduced mode");
	property p_frame_end;
		@(posedge clk) disable iff (!nrst || sync_rst)
			(take && !frame_tick && bit_reg == LAST_BIT && blk_reg == LAST_BLOCK) |=> !active_reg;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame runs past eight blocks");
	// A stalled receiver must see the same element until it pops it
	property p_stall_hold;
		@(posedge clk) disable iff (!nrst || sync_rst) (out_valid && !out_ready) |=> out_valid && $stable(out_elem);
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("stalled element lost");
endmodule // sysctl_seq_assembler

// File: tb/ref_sink.sv
/*
 Receiver model for the reference control stream.
 Assumes one bit per popped element and frame_start on the first bit.
*/
`timescale 1ns/1ns
module ref_sink
	import sysctl_seq_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic stall,
	input wire logic out_valid,
	input wire ref_elem_s out_elem,
	output logic out_ready,
	output logic [255:0] frame_bits,
	output int got
);
	// ==========
	// Capture
	// Stalls on demand so the buffer is pushed to full
	assign out_ready = !stall;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_bits <= '0;
			got <= 0;
		end else if (out_valid && out_ready) begin
			// First bit of a frame lands on the top index
			frame_bits[255 - (out_elem.frame_start ? 0 : got)] <= out_elem.bit_value;
			got <= out_elem.frame_start ? 1 : got + 1;
		end
	end
endmodule // ref_sink

// File: tb/testbench.sv
/*
 Self-checking bench for the sequence assembler.
 Assumes the receiver model ref_sink and a 250 MHz clock.
*/
`timescale 1ns/1ns
module testbench;
	import sysctl_seq_pkg::*;
	logic clk, nrst, sync_rst, symbol_tick, frame_tick, in_ready, out_valid, out_ready, block_tick, stall;
	sys_config_s cfg;
	ref_elem_s out_elem;
	logic [CNT_W-1:0] block_count_out, exp_bc;
	logic [255:0] frame_bits;
	int got, errors, compares, i, ticks, pops;
	localparam int FRAME_BITS = SEQ_BITS * BLOCKS_PER_FRAME;
	sysctl_seq_assembler u_sysctl_seq_assembler (.clk(clk), .nrst(nrst), .sync_rst(sync_rst),
		.symbol_tick(symbol_tick), .frame_tick(frame_tick), .cfg(cfg), .in_ready(in_ready),
		.out_valid(out_valid), .out_ready(out_ready), .out_elem(out_elem), .block_tick(block_tick),
		.block_count_out(block_count_out));
	ref_sink u_ref_sink (.clk(clk), .nrst(nrst), .stall(stall), .out_valid(out_valid),
		.out_elem(out_elem), .out_ready(out_ready), .frame_bits(frame_bits), .got(got));
	// ==========
	// Helpers
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Flags that do not apply in reduced width read as zero
	function automatic logic [31:0] exp_seq(sys_config_s c, logic [2:0] bc);
		logic pl, hp;
		pl = c.power_level_flag & !c.reduced_digital_width_flag;
		hp = c.high_power_pids_flag & !c.reduced_digital_width_flag;
		exp_seq = {7'h32, pl, pl, 1'b1, 1'b0, hp, c.analog_audio_width_flag, hp ^ c.analog_audio_width_flag,
			1'b0, c.reduced_digital_width_flag, 1'b0, bc, ^{c.reduced_digital_width_flag, bc}, 2'h3, 3'h0,
			c.service_mode_code, ^c.service_mode_code};
	endfunction
	// Ticks continue past 256 bits without frame_tick; those must be refused
	task automatic send_frame(sys_config_s c);
		int n;
		n = 0;
		cfg = c;
		while (n < 260) begin
			@(posedge clk);
			#1;
			symbol_tick = 1'b1;
			frame_tick = (n == 0);
			stall = (i % 5) < 3;
			i++;
			@(negedge clk);
			if (in_ready || n >= 256) n++;
		end
		@(posedge clk);
		#1;
		symbol_tick = 1'b0;
		stall = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		check("popped", got, 256);
		for (int j = 0; j < 8; j++) begin
			check("sequence", frame_bits[32*(7-j) +: 32], exp_seq(c, 3'(j)));
		end
	endtask
	// ==========
	// Block count monitor
	always @(negedge clk) begin
		if (nrst && block_tick) begin
			check("block_count", 32'(block_count_out), 32'(exp_bc));
			exp_bc = exp_bc + 3'h1;
			ticks++;
		end
	end
	// ==========
	// Popped element monitor: position in the frame fixes its tags
	always @(negedge clk) begin
		if (nrst && out_valid && out_ready) begin
			check("frame_start", 32'(out_elem.frame_start), 32'(pops % FRAME_BITS == 0));
			check("elem_block", 32'(out_elem.block_counter), 32'((pops % FRAME_BITS) / SEQ_BITS));
			pops++;
		end
	end
	// ==========
	// Tests
	initial begin
		#40000;
		errors++;
		print_verdict();
	end
	initial begin
		nrst = 1'b0;
		sync_rst = 1'b0;
		symbol_tick = 1'b0;
		frame_tick = 1'b0;
		stall = 1'b0;
		cfg = '0;
		exp_bc = 3'h0;
		errors = 0;
		compares = 0;
		i = 0;
		ticks = 0;
		pops = 0;
		repeat (3) @(posedge clk);
		#1;
		nrst = 1'b1;
		check("idle_valid", 32'(out_valid), 32'h0);
		check("idle_ready", 32'(in_ready), 32'h1);
		send_frame(9'h1D5);
		send_frame(9'h1AA);
		check("block_ticks", ticks, 16);
		// Abandon a frame part way; a synchronous reset must then empty the buffer
		for (int k = 0; k < 40; k++) begin
			symbol_tick = 1'b1;
			frame_tick = (k == 0);
			stall = (k % 5) < 3;
			@(posedge clk);
			#1;
		end
		symbol_tick = 1'b0;
		frame_tick = 1'b0;
		@(posedge clk);
		#1;
		sync_rst = 1'b1;
		stall = 1'b1;
		exp_bc = 3'h0;
		pops = 0;
		@(posedge clk);
		#1;
		sync_rst = 1'b0;
		stall = 1'b0;
		check("flushed", 32'(out_valid), 32'h0);
		check("ready_after_flush", 32'(in_ready), 32'h1);
		send_frame(9'h0C6);
		print_verdict();
	end
endmodule // testbench
